// ==== pkg/cps_pkg.sv ====
// package for the protocol status and bus-off recovery block
// assumes an APB master and a CAN protocol engine that reports events as pulses
package cps_pkg;
  localparam logic [11:0] CPS_ADDR_STATUS = 12'h000;
  localparam logic [11:0] CPS_ADDR_CONTROL = 12'h004;
  localparam logic [11:0] CPS_ADDR_COUNTERS = 12'h008;
  localparam int CPS_LEC_LSB = 0;
  localparam int CPS_ACT_LSB = 3;
  localparam int CPS_PASSIVE_BIT = 5;
  localparam int CPS_WARN_BIT = 6;
  localparam int CPS_BUSOFF_BIT = 7;
  localparam int CPS_DATA_PHASE_ERROR_CODE_LSB = 8;
  localparam int CPS_INIT_BIT = 0;
  localparam int CPS_REC_LSB = 8;
  localparam logic [8:0] CPS_WARN_LIMIT = 9'h060;
  localparam logic [8:0] CPS_PASSIVE_LIMIT = 9'h080;
  localparam logic [8:0] CPS_BUSOFF_LIMIT = 9'h100;
  localparam logic [7:0] CPS_IDLE_RUNS = 8'h81;
  localparam logic [2:0] CPS_CODE_RESET = 3'h7;

  typedef enum logic [2:0]
  {
    CPS_LEC_NONE = 3'h0,
    CPS_LEC_STUFF = 3'h1,
    CPS_LEC_FORM = 3'h2,
    CPS_LEC_ACK = 3'h3,
    CPS_LEC_BIT1 = 3'h4,
    CPS_LEC_BIT0 = 3'h5,
    CPS_LEC_CRC = 3'h6,
    CPS_LEC_NOCHANGE = 3'h7
  } cps_code_t;

  typedef enum logic [1:0]
  {
    CPS_ACT_SYNC = 2'h0,
    CPS_ACT_IDLE = 2'h1,
    CPS_ACT_RX = 2'h2,
    CPS_ACT_TX = 2'h3
  } cps_act_t;

  typedef enum logic [1:0]
  {
    CPS_ST_ACTIVE = 2'h0,
    CPS_ST_BUSOFF = 2'h1,
    CPS_ST_RECOVER = 2'h2
  } cps_state_t;

  // one-cycle event pulses from the protocol engine
  typedef struct packed
  {
    logic frameOk;
    logic stuffErr;
    logic formErr;
    logic ackErr;
    logic bit1Err;
    logic bit0Err;
    logic crcErr;
    logic fdStuffBit;
    logic dataPhase;
    logic txErrInc;
    logic rxErrInc;
    logic txErrDec;
    logic rxErrDec;
    logic recessiveRun;
  } cps_event_t;

  typedef struct packed
  {
    logic [11:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } cps_apb_req_t;
endpackage : cps_pkg

// ==== rtl/cps_status.sv ====
// protocol status register, error counters and bus-off recovery
// assumes synchronous APB master and event pulses on clk from the protocol engine
//
// Added by the designer: the register addresses and register access over APB.
`timescale 1ns/1ps
module cps_status
(
  input wire logic clk,
  input wire logic reset_n,
  input wire cps_pkg::cps_apb_req_t apbReq,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire cps_pkg::cps_event_t events,
  input wire cps_pkg::cps_act_t engineAct,
  output logic busEnable,
  output logic [1:0] activityState
);
  logic [2:0] lastErrorCode;
  logic [2:0] next_lastErrorCode;
  logic [2:0] dataPhaseErrorCode;
  logic [2:0] next_dataPhaseErrorCode;
  logic inDataPhase;
  logic next_inDataPhase;
  logic [8:0] txCount;
  logic [8:0] next_txCount;
  logic [8:0] rxCount;
  logic [8:0] next_rxCount;
  logic [7:0] runCount;
  logic [7:0] next_runCount;
  logic initControlBit;
  logic next_initControlBit;
  cps_pkg::cps_state_t state;
  cps_pkg::cps_state_t next_state;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic next_busEnable;
  logic [1:0] next_activityState;
  logic warningFlag;
  logic passiveFlag;
  logic access;
  logic statusRead;
  logic ctrlWrite;
  logic recovering;
  logic [31:0] statusWord;

  // slave answers in the cycle after setup: pready rises with the access phase
  assign access = apbReq.psel & apbReq.penable & pready;
  assign statusRead = access & ~apbReq.pwrite & (apbReq.paddr == cps_pkg::CPS_ADDR_STATUS);
  assign ctrlWrite = access & apbReq.pwrite & (apbReq.paddr == cps_pkg::CPS_ADDR_CONTROL);
  assign recovering = (state == cps_pkg::CPS_ST_RECOVER);
  assign warningFlag = (txCount >= cps_pkg::CPS_WARN_LIMIT)
    | (rxCount >= cps_pkg::CPS_WARN_LIMIT);
  assign passiveFlag = (state == cps_pkg::CPS_ST_ACTIVE)
    & ((txCount >= cps_pkg::CPS_PASSIVE_LIMIT) | (rxCount >= cps_pkg::CPS_PASSIVE_LIMIT));

  always_comb
  begin
    statusWord = 32'h0000_0000;
    statusWord[cps_pkg::CPS_LEC_LSB +: 3] = lastErrorCode;
    statusWord[cps_pkg::CPS_ACT_LSB +: 2] = activityState;
    statusWord[cps_pkg::CPS_PASSIVE_BIT] = passiveFlag;
    statusWord[cps_pkg::CPS_WARN_BIT] = warningFlag;
    statusWord[cps_pkg::CPS_BUSOFF_BIT] = (state != cps_pkg::CPS_ST_ACTIVE);
    statusWord[cps_pkg::CPS_DATA_PHASE_ERROR_CODE_LSB +: 3] = dataPhaseErrorCode;
  end

  // error codes: read reloads only the last error code first, then events; an event in the read cycle wins
  always_comb
  begin
    logic [2:0] code;
    logic hit;
    code = cps_pkg::CPS_LEC_NONE;
    hit = 1'b1;
    if (events.crcErr)
      code = cps_pkg::CPS_LEC_CRC;
    else if (events.bit0Err | (recovering & events.recessiveRun))
      code = cps_pkg::CPS_LEC_BIT0;
    else if (events.bit1Err)
      code = cps_pkg::CPS_LEC_BIT1;
    else if (events.ackErr)
      code = cps_pkg::CPS_LEC_ACK;
    else if (events.formErr | (events.stuffErr & events.fdStuffBit))
      code = cps_pkg::CPS_LEC_FORM;
    else if (events.stuffErr)
      code = cps_pkg::CPS_LEC_STUFF;
    else if (events.frameOk)
      code = cps_pkg::CPS_LEC_NONE;
    else
      hit = 1'b0;
    next_lastErrorCode = statusRead ? cps_pkg::CPS_CODE_RESET : lastErrorCode;
    next_dataPhaseErrorCode = dataPhaseErrorCode;
    next_inDataPhase = inDataPhase | events.dataPhase;
    if (hit & inDataPhase & ~(recovering & events.recessiveRun))
    begin
      next_dataPhaseErrorCode = code;
      next_inDataPhase = 1'b0;
    end
    else if (hit)
      next_lastErrorCode = code;
  end

  // fault confinement and bus-off recovery
  always_comb
  begin
    next_state = state;
    next_txCount = txCount;
    next_rxCount = rxCount;
    next_runCount = runCount;
    next_initControlBit = initControlBit;
    if (ctrlWrite)
      next_initControlBit = apbReq.pwdata[cps_pkg::CPS_INIT_BIT];
    unique case (state)
      cps_pkg::CPS_ST_ACTIVE:
      begin
        if (events.txErrInc)
          next_txCount = txCount + 9'h008;
        else if (events.txErrDec && txCount != 9'h000)
          next_txCount = txCount - 9'h001;
        if (events.rxErrInc && rxCount < cps_pkg::CPS_BUSOFF_LIMIT)
          next_rxCount = rxCount + 9'h001;
        else if (events.rxErrDec && rxCount != 9'h000)
          next_rxCount = rxCount - 9'h001;
        if (next_txCount >= cps_pkg::CPS_BUSOFF_LIMIT)
        begin
          next_state = cps_pkg::CPS_ST_BUSOFF;
          next_initControlBit = 1'b1;
        end
      end
      cps_pkg::CPS_ST_BUSOFF:
      begin
        next_runCount = 8'h00;
        if (!next_initControlBit)
        begin
          next_state = cps_pkg::CPS_ST_RECOVER;
          next_rxCount = 9'h000;
        end
      end
      cps_pkg::CPS_ST_RECOVER:
      begin
        // init writes are ignored here so software cannot cut the wait short
        next_initControlBit = 1'b0;
        if (events.recessiveRun)
        begin
          next_runCount = runCount + 8'h01;
          next_rxCount = rxCount + 9'h001;
          if (next_runCount == cps_pkg::CPS_IDLE_RUNS)
          begin
            next_state = cps_pkg::CPS_ST_ACTIVE;
            next_txCount = 9'h000;
            next_rxCount = 9'h000;
            next_runCount = 8'h00;
          end
        end
      end
      default:
        next_state = cps_pkg::CPS_ST_ACTIVE;
    endcase
  end

  // bus side outputs and APB answer
  always_comb
  begin
    next_busEnable = (next_state == cps_pkg::CPS_ST_ACTIVE) & ~next_initControlBit;
    next_activityState = next_busEnable ? engineAct : cps_pkg::CPS_ACT_SYNC;
    next_pready = apbReq.psel & ~apbReq.penable;
    next_pslverr = 1'b0;
    next_prdata = prdata;
    if (apbReq.psel & ~apbReq.penable)
    begin
      next_prdata = 32'h0000_0000;
      unique case (apbReq.paddr)
        cps_pkg::CPS_ADDR_STATUS:
          next_prdata = statusWord;
        cps_pkg::CPS_ADDR_CONTROL:
          next_prdata = {31'h0000_0000, initControlBit};
        cps_pkg::CPS_ADDR_COUNTERS:
          next_prdata = {15'h0000, rxCount[7:0], txCount[8:1], txCount[0]};
        default:
          next_pslverr = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      lastErrorCode <= cps_pkg::CPS_CODE_RESET;
      dataPhaseErrorCode <= cps_pkg::CPS_CODE_RESET;
      inDataPhase <= 1'b0;
      txCount <= 9'h000;
      rxCount <= 9'h000;
      runCount <= 8'h00;
      initControlBit <= 1'b1;
      state <= cps_pkg::CPS_ST_ACTIVE;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      busEnable <= 1'b0;
      activityState <= cps_pkg::CPS_ACT_SYNC;
    end
    else
    begin
      lastErrorCode <= next_lastErrorCode;
      dataPhaseErrorCode <= next_dataPhaseErrorCode;
      inDataPhase <= next_inDataPhase;
      txCount <= next_txCount;
      rxCount <= next_rxCount;
      runCount <= next_runCount;
      initControlBit <= next_initControlBit;
      state <= next_state;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      busEnable <= next_busEnable;
      activityState <= next_activityState;
    end
  end
endmodule : cps_status

// ==== tb/cps_engine_model.sv ====
// stand-in for the CAN engine and the bus beyond it
// assumes the bench commands every event word and the activity level
`timescale 1ns/1ps
module cps_engine_model
(
  input wire logic clk,
  output cps_pkg::cps_event_t events,
  output cps_pkg::cps_act_t engineAct
);
  initial
  begin
    events = '0;
    engineAct = cps_pkg::CPS_ACT_SYNC;
  end
  // apart from its initial value, the activity level is driven only from here, right after a rising edge
  task automatic setAct(input cps_pkg::cps_act_t a);
    @(posedge clk);
    engineAct <= a;
  endtask : setAct
  // a quiet cycle after each pulse keeps events from merging
  task automatic pulse(input logic [13:0] ev, input int n);
    repeat (n)
    begin
      @(posedge clk);
      events <= ev;
      @(posedge clk);
      events <= '0;
    end
  endtask : pulse
endmodule : cps_engine_model

// ==== tb/cps_status_sva.sv ====
// port checker for the protocol status block
// assumes one clock domain and the single-cycle APB answer of the block
`timescale 1ns/1ps
module cps_status_sva
(
  input wire logic clk,
  input wire logic reset_n,
  input wire cps_pkg::cps_apb_req_t apbReq,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire cps_pkg::cps_event_t events,
  input wire cps_pkg::cps_act_t engineAct,
  input wire logic busEnable,
  input wire logic [1:0] activityState
);
  logic mapped;
  logic quiet;
  logic cause;
  assign mapped = apbReq.paddr inside {12'h000, 12'h004, 12'h008};
  assign quiet = events == '0;
  // a rise of the bus enable needs an init write of 0 or a recessive run shortly before
  assign cause = events.recessiveRun || (apbReq.psel && apbReq.penable && pready
    && apbReq.pwrite && apbReq.paddr == 12'h004 && !apbReq.pwdata[0]);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  sequence s_setup;
    apbReq.psel && !apbReq.penable;
  endsequence
  sequence s_rdStat;
    (s_setup and quiet) ##1 (pready && apbReq.penable && !apbReq.pwrite
      && apbReq.paddr == 12'h000 && quiet);
  endsequence
  property p_lec7;
    s_rdStat ##1 (!apbReq.psel && quiet) ##1 s_rdStat |-> prdata[2:0] == 3'h7;
  endproperty
  property p_act;
    $past(busEnable) && busEnable |-> activityState == $past(engineAct);
  endproperty
  property p_off;
    !busEnable && !$past(busEnable) |-> activityState == 2'h0;
  endproperty
  property p_rise;
    $rose(busEnable) |-> $past(cause) || $past(cause, 2) || $past(cause, 3);
  endproperty
  property p_ready;
    s_setup |=> pready;
  endproperty
  property p_once;
    pready |=> !pready;
  endproperty
  property p_noreq;
    !apbReq.psel |=> !pready;
  endproperty
  property p_slverr;
    pready && !mapped && !apbReq.pwrite |-> pslverr && prdata == 32'h0;
  endproperty
  a_lec7: assert property (p_lec7) else $error("code not reloaded by read");
  a_act: assert property (p_act) else $error("activity not copied");
  a_off: assert property (p_off) else $error("activity while bus off");
  a_rise: assert property (p_rise) else $error("bus enabled without cause");
  a_ready: assert property (p_ready) else $error("no answer after setup");
  a_once: assert property (p_once) else $error("ready held too long");
  a_noreq: assert property (p_noreq) else $error("ready without select");
  a_slverr: assert property (p_slverr) else $error("unmapped read not refused");
endmodule : cps_status_sva
bind cps_status cps_status_sva u_sva (.clk(clk), .reset_n(reset_n), .apbReq(apbReq),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .events(events),
  .engineAct(engineAct), .busEnable(busEnable), .activityState(activityState));

// ==== tb/tb_top.sv ====
// self-checking bench: APB accesses against commanded engine events
// assumes the status block and the engine model on one clock
`timescale 1ns/1ps
module tb_top;
  logic clk;
  logic reset_n;
  cps_pkg::cps_apb_req_t req;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  cps_pkg::cps_event_t events;
  cps_pkg::cps_act_t engineAct;
  logic busEnable;
  logic [1:0] activityState;
  logic [31:0] rdata;
  logic rerr;
  int mismatches;
  int nCompared;
  cps_engine_model u_eng (.clk(clk), .events(events), .engineAct(engineAct));
  cps_status u_dut (.clk(clk), .reset_n(reset_n), .apbReq(req), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .events(events), .engineAct(engineAct),
    .busEnable(busEnable), .activityState(activityState));
  task automatic giveVerdict();
    $display("compared %0d mismatches %0d", nCompared, mismatches);
    if (mismatches == 0 && nCompared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : giveVerdict
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    nCompared++;
    if (g !== e)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // values read right after a rising edge are the ones the slave showed at that edge
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    req <= '{a, 1'b1, 1'b0, w, d};
    @(posedge clk);
    req.penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
    begin
      k++;
      if (k > 50)
      begin
        mismatches++;
        giveVerdict();
      end
      @(posedge clk);
    end
    rdata = prdata;
    rerr = pslverr;
    req <= '0;
  endtask : apb
  task automatic rdChk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e,
    input string n);
    apb(a, 1'b0, 32'h0);
    chk(n, e, rdata & m);
  endtask : rdChk
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial
  begin
    reset_n = 1'b0;
    req = '0;
    mismatches = 0;
    nCompared = 0;
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    rdChk(12'h000, 32'h7FF, 32'h707, "status at reset");
    rdChk(12'h004, 32'h1, 32'h1, "init at reset");
    apb(12'h00C, 1'b0, 32'h0);
    chk("unmapped data", 32'h0, rdata);
    chk("unmapped error", 32'h1, {31'h0, rerr});
    apb(12'h004, 1'b1, 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      u_eng.setAct(cps_pkg::cps_act_t'(i));
      rdChk(12'h000, 32'h18, i << 3, "activity");
    end
    for (int i = 0; i < 7; i++)
    begin
      u_eng.pulse(14'h2000 >> i, 1);
      rdChk(12'h000, 32'h7, i, "last code");
    end
    rdChk(12'h000, 32'h7, 32'h7, "code after read");
    u_eng.pulse(14'h1040, 1);
    rdChk(12'h000, 32'h7, 32'h2, "fd stuff bit");
    u_eng.pulse(14'h0020, 1);
    u_eng.pulse(14'h0080, 1);
    rdChk(12'h000, 32'h707, 32'h607, "data phase code");
    u_eng.pulse(14'h0008, 95);
    rdChk(12'h000, 32'h60, 32'h0, "warn at 95");
    u_eng.pulse(14'h0008, 1);
    rdChk(12'h000, 32'h60, 32'h40, "warn at 96");
    u_eng.pulse(14'h0008, 32);
    repeat (2) rdChk(12'h000, 32'hF8, 32'h78, "flags");
    u_eng.pulse(14'h0010, 32);
    rdChk(12'h000, 32'h98, 32'h80, "bus-off");
    rdChk(12'h004, 32'h1, 32'h1, "init set");
    apb(12'h004, 1'b1, 32'h1);
    apb(12'h004, 1'b1, 32'h0);
    u_eng.pulse(14'h0001, 128);
    apb(12'h004, 1'b1, 32'h1);
    apb(12'h004, 1'b1, 32'h0);
    @(negedge clk);
    chk("bus held off", 32'h0, {31'h0, busEnable});
    rdChk(12'h000, 32'h7, 32'h5, "run code");
    rdChk(12'h008, 32'h1FE00, 32'h10000, "run count");
    u_eng.pulse(14'h0001, 1);
    repeat (3) @(negedge clk);
    chk("bus resumed", 32'h1, {31'h0, busEnable});
    rdChk(12'h008, 32'hFFFF, 32'h0, "counters cleared");
    giveVerdict();
  end
endmodule : tb_top
